// ---- dccl_defs.vh ----
// Constants for the delay chain and converter configuration loader.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef DCCL_DEFS_VH
`define DCCL_DEFS_VH
// ************************************************************
// Chain geometry
// ************************************************************
`define DCCL_CHIPS          10
`define DCCL_BITS_PER_CHIP  8
`define DCCL_CHAIN_BITS     80
`define DCCL_CNT_W          7
// ************************************************************
// Converter word: 3 address bits, 12 data bits
// ************************************************************
`define DCCL_CONV_BITS      15
`define DCCL_CONV_REGS      4
// ************************************************************
// Timing
// ************************************************************
`define DCCL_CLK_MHZ        250
`define DCCL_SHIFT_DIV      8
`define DCCL_PIX_DIV        2
`define DCCL_PIX_DIV_MIN    2
`define DCCL_TICK_MS        1
// ************************************************************
// Default delay codes, chain order
// ************************************************************
`define DCCL_DLY_OUTCLK     8'h10
`define DCCL_DLY_REF2       8'h20
`define DCCL_DLY_REF1       8'h20
`define DCCL_DLY_DAT2       8'h30
`define DCCL_DLY_DAT1       8'h30
`define DCCL_DLY_HP1A       8'h00
`define DCCL_DLY_HP1B       8'h00
`define DCCL_DLY_HP2A       8'h00
`define DCCL_DLY_HP2B       8'h00
`define DCCL_DLY_RST        8'h08
// Converter defaults {addr,data}
`define DCCL_CONV_W0        15'h0000
`define DCCL_CONV_W1        15'h1100
`define DCCL_CONV_W2        15'h2080
`define DCCL_CONV_W3        15'h3000
`endif

// ---- dccl_sync.v ----
// Three-stage input synchroniser for one pin.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module dccl_sync (
	input  wire clk,   // System clock
	input  wire rst,   // Async reset, high
	input  wire din,   // Pin level
	output reg  dout   // Agreed level
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	// Second and third stages must agree before the level moves
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			dout  <= 1'b0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				dout <= s3_ff;
		end
	end
endmodule // dccl_sync

// ---- dccl_loader.v ----
// Configuration loader: default delay chain and converter loads after reset,
// then pass-through of the external serial port; pixel and integration timing.
// Assumes pins arrive asynchronously and pulled low when unconnected.
`timescale 1ns/100ps
`include "dccl_defs.vh"
// What this block does
// - After reset, shift default settings into all ten delay chips.
// - After reset, write default registers into both converters.
// - Port is shift clock, data and three separate latch strobes.
// - Chain load is eight bits per chip, eighty bits total.
// - Each chip byte goes most significant bit first.
// - Chain order: outclk, ref2, ref1, dat2, dat1, horiz 1a, 1b, 2a, 2b, reset.
// - Pixel timing divides the master clock, at most half its rate.
// - Integration counts whole one millisecond ticks.
// - Unconnected inputs read zero; block runs without them.
// - Each converter rewritable alone via its own strobe.
module dccl_loader (
	input  wire       CLOCK,          // 250 MHz master clock
	input  wire       RST,            // Async reset / board reset, high
	input  wire       EXT_SCLK,       // External shift clock pin
	input  wire       EXT_DATA,       // External data pin
	input  wire       EXT_CHAIN_LD,   // External chain strobe pin
	input  wire       EXT_CONV1_LD,   // External converter 1 strobe pin
	input  wire       EXT_CONV2_LD,   // External converter 2 strobe pin
	input  wire       UNIT_TICK,      // 1 kHz integration tick pin
	input  wire       INT_MODE,       // Internal integration mode pin
	input  wire [7:0] INT_UNITS,      // Integration length in ticks
	output reg        SERIAL_SHIFT_CLOCK,      // Shift clock to targets
	output reg        SERIAL_DATA_LINE,        // Shared data line
	output reg        DELAY_CHAIN_LATCH_STROBE,// Chain strobe
	output reg        CONVERTER1_LATCH_STROBE, // Converter 1 strobe
	output reg        CONVERTER2_LATCH_STROBE, // Converter 2 strobe
	output reg        PIXEL_ENABLE,            // Pixel-rate pulse
	output reg        INTEGRATING,             // High during integration
	output reg        DEFAULTS_DONE            // Default loads finished
);
	// ************************************************************
	// States
	// ************************************************************
	localparam [5:0] S_CHAIN = 6'h01;
	localparam [5:0] S_CLAT  = 6'h02;
	localparam [5:0] S_CONV  = 6'h04;
	localparam [5:0] S_VLAT  = 6'h08;
	localparam [5:0] S_GAP   = 6'h10;
	localparam [5:0] S_PASS  = 6'h20;
	localparam [79:0] CHAIN_IMG = {`DCCL_DLY_OUTCLK, `DCCL_DLY_REF2, `DCCL_DLY_REF1,
		`DCCL_DLY_DAT2, `DCCL_DLY_DAT1, `DCCL_DLY_HP1A, `DCCL_DLY_HP1B,
		`DCCL_DLY_HP2A, `DCCL_DLY_HP2B, `DCCL_DLY_RST};
	localparam [59:0] CONV_IMG = {`DCCL_CONV_W0, `DCCL_CONV_W1, `DCCL_CONV_W2, `DCCL_CONV_W3};
	localparam [3:0] HALF = 4'd`DCCL_SHIFT_DIV >> 1;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// Length bits may settle a cycle apart, so change the length only while idle
	wire [7:1] pin_raw = {EXT_SCLK, EXT_DATA, EXT_CHAIN_LD, EXT_CONV1_LD,
		EXT_CONV2_LD, UNIT_TICK, INT_MODE};
	wire [7:1] pin_s;
	wire [7:0] units_s;  // Integration length, settled
	genvar gi;
	generate
		for (gi = 1; gi < 8; gi = gi + 1) begin : g_sync
			dccl_sync u_sync (
				.clk  (CLOCK),
				.rst  (RST),
				.din  (pin_raw[gi]),
				.dout (pin_s[gi])
			);
		end
		for (gi = 0; gi < 8; gi = gi + 1) begin : g_units
			dccl_sync u_sync (
				.clk  (CLOCK),
				.rst  (RST),
				.din  (INT_UNITS[gi]),
				.dout (units_s[gi])
			);
		end
	endgenerate

	// ************************************************************
	// Shift-rate divider: one enable per half shift clock
	// ************************************************************
	reg  [3:0] div_ff;
	wire       half_en = (div_ff == HALF - 4'h1);
	always @(posedge CLOCK or posedge RST) begin
		if (RST)
			div_ff <= 4'h0;
		else if (half_en)
			div_ff <= 4'h0;
		else
			div_ff <= div_ff + 4'h1;
	end

	// ************************************************************
	// Default load sequencer
	// ************************************************************
	reg [5:0]  state_ff;
	reg [6:0]  bit_ff;     // Bits remaining in current word
	reg [2:0]  word_ff;    // Converter word index
	reg        conv_ff;    // 0: converter 1, 1: converter 2
	reg        phase_ff;   // 0: clock low half, 1: high half
	reg [79:0] sh_ff;
	reg        sclk_ff;
	reg        sdat_ff;
	reg        ld_chain_ff;
	reg        ld_c1_ff;
	reg        ld_c2_ff;
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_ff    <= S_CHAIN;
			bit_ff      <= 7'd`DCCL_CHAIN_BITS;
			word_ff     <= 3'h0;
			conv_ff     <= 1'b0;
			phase_ff    <= 1'b0;
			sh_ff       <= CHAIN_IMG;
			sclk_ff     <= 1'b0;
			sdat_ff     <= 1'b0;
			ld_chain_ff <= 1'b0;
			ld_c1_ff    <= 1'b0;
			ld_c2_ff    <= 1'b0;
		end else if (half_en) begin
			case (state_ff)
				S_CHAIN, S_CONV: begin
					// Present data while low, rise mid-bit
					if (!phase_ff) begin
						sdat_ff  <= sh_ff[79];
						sclk_ff  <= 1'b0;
						phase_ff <= 1'b1;
					end else begin
						sclk_ff  <= 1'b1;
						phase_ff <= 1'b0;
						sh_ff    <= {sh_ff[78:0], 1'b0};
						bit_ff   <= bit_ff - 7'h1;
						if (bit_ff == 7'h1)
							state_ff <= (state_ff == S_CHAIN) ? S_CLAT : S_VLAT;
					end
				end
				S_CLAT: begin
					// Whole chain latched at once after the last bit
					sclk_ff <= 1'b0;
					if (!ld_chain_ff) begin
						ld_chain_ff <= 1'b1;
					end else begin
						ld_chain_ff <= 1'b0;
						state_ff    <= S_GAP;
					end
				end
				S_VLAT: begin
					sclk_ff <= 1'b0;
					if (!(ld_c1_ff | ld_c2_ff)) begin
						ld_c1_ff <= ~conv_ff;
						ld_c2_ff <= conv_ff;
					end else begin
						ld_c1_ff <= 1'b0;
						ld_c2_ff <= 1'b0;
						if (word_ff == 3'd`DCCL_CONV_REGS - 3'd1) begin
							word_ff  <= 3'h0;
							conv_ff  <= 1'b1;
							state_ff <= conv_ff ? S_PASS : S_GAP;
						end else begin
							word_ff  <= word_ff + 3'h1;
							state_ff <= S_GAP;
						end
					end
				end
				S_GAP: begin
					// Load next converter word, top aligned
					sh_ff    <= {CONV_IMG[59 - 15 * word_ff -: 15], 65'h0};
					bit_ff   <= 7'd`DCCL_CONV_BITS;
					state_ff <= S_CONV;
				end
				S_PASS: begin
					sclk_ff <= 1'b0;
				end
				default: state_ff <= S_CHAIN;
			endcase
		end
	end

	// ************************************************************
	// Output mux: external port only after defaults are loaded
	// ************************************************************
	wire pass = (state_ff == S_PASS);
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			SERIAL_SHIFT_CLOCK       <= 1'b0;
			SERIAL_DATA_LINE         <= 1'b0;
			DELAY_CHAIN_LATCH_STROBE <= 1'b0;
			CONVERTER1_LATCH_STROBE  <= 1'b0;
			CONVERTER2_LATCH_STROBE  <= 1'b0;
			DEFAULTS_DONE            <= 1'b0;
		end else begin
			SERIAL_SHIFT_CLOCK       <= pass ? pin_s[7] : sclk_ff;
			SERIAL_DATA_LINE         <= pass ? pin_s[6] : sdat_ff;
			DELAY_CHAIN_LATCH_STROBE <= pass ? pin_s[5] : ld_chain_ff;
			CONVERTER1_LATCH_STROBE  <= pass ? pin_s[4] : ld_c1_ff;
			CONVERTER2_LATCH_STROBE  <= pass ? pin_s[3] : ld_c2_ff;
			DEFAULTS_DONE            <= pass;
		end
	end

	// ************************************************************
	// Pixel-rate enable, never faster than half the master clock
	// ************************************************************
	localparam [3:0] PDIV = (4'd`DCCL_PIX_DIV < 4'd`DCCL_PIX_DIV_MIN) ? 4'd`DCCL_PIX_DIV_MIN : 4'd`DCCL_PIX_DIV;
	reg [3:0] pix_ff;
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pix_ff       <= 4'h0;
			PIXEL_ENABLE <= 1'b0;
		end else begin
			PIXEL_ENABLE <= (pix_ff == PDIV - 4'h1);
			pix_ff       <= (pix_ff == PDIV - 4'h1) ? 4'h0 : pix_ff + 4'h1;
		end
	end

	// ************************************************************
	// Integration in whole ticks; pins pulled low keep it idle
	// ************************************************************
	reg       tick_d_ff;
	reg [7:0] icnt_ff;
	wire      tick_rise = pin_s[2] & ~tick_d_ff;
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			tick_d_ff   <= 1'b0;
			icnt_ff     <= 8'h00;
			INTEGRATING <= 1'b0;
		end else begin
			tick_d_ff <= pin_s[2];
			if (!pin_s[1] || units_s == 8'h00) begin
				INTEGRATING <= 1'b0;
				icnt_ff     <= 8'h00;
			end else if (tick_rise) begin
				// Window opens and closes on tick edges here; mode pin low or zero length closes it at once
				if (!INTEGRATING) begin
					INTEGRATING <= 1'b1;
					icnt_ff     <= units_s;
				end else if (icnt_ff == 8'h01) begin
					INTEGRATING <= 1'b0;
					icnt_ff     <= 8'h00;
				end else begin
					icnt_ff <= icnt_ff - 8'h01;
				end
			end
		end
	end
endmodule // dccl_loader

// ---- dccl_monitor.sv ----
// Checker for the loader's serial port and timing outputs.
// Assumes a bind onto dccl_loader.
`timescale 1ns/100ps
module dccl_monitor (
	input wire CLOCK,                    // Clock
	input wire RST,                      // Reset
	input wire INT_MODE,                 // Mode pin
	input wire SERIAL_SHIFT_CLOCK,       // Shift clock
	input wire SERIAL_DATA_LINE,         // Data
	input wire DELAY_CHAIN_LATCH_STROBE, // Chain strobe
	input wire CONVERTER1_LATCH_STROBE,  // Strobe 1
	input wire CONVERTER2_LATCH_STROBE,  // Strobe 2
	input wire PIXEL_ENABLE,             // Pixel pulse
	input wire INTEGRATING,              // Integration
	input wire DEFAULTS_DONE             // Loads done
);
	wire       conv = CONVERTER1_LATCH_STROBE | CONVERTER2_LATCH_STROBE; // Either converter
	wire       strb = conv | DELAY_CHAIN_LATCH_STROBE;                    // Any strobe
	wire       init = !DEFAULTS_DONE;                                      // Default phase
	wire       sck  = SERIAL_SHIFT_CLOCK;                                  // Short name
	reg        sclk_ff;  // Shift clock last cycle
	reg        chain_ff; // Chain latched
	reg  [6:0] rise_ff;  // Edges since strobe
	// Count restarts on a strobe so each word is measured alone
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sclk_ff  <= 1'b0;
			chain_ff <= 1'b0;
			rise_ff  <= 7'h00;
		end else begin
			sclk_ff  <= SERIAL_SHIFT_CLOCK;
			chain_ff <= chain_ff | DELAY_CHAIN_LATCH_STROBE;
			rise_ff  <= strb ? 7'h00 : rise_ff + (SERIAL_SHIFT_CLOCK & ~sclk_ff);
		end
	end
	default clocking mon_cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);
	AST_PIX_PULSE: assert property (PIXEL_ENABLE |=> !PIXEL_ENABLE) else $error("pixel pulse");
	AST_ONE_STROBE: assert property ($onehot0({CONVERTER1_LATCH_STROBE, CONVERTER2_LATCH_STROBE,
		DELAY_CHAIN_LATCH_STROBE})) else $error("strobes");
	AST_STROBE_LEN: assert property ($rose(strb) && init |-> strb [*4] ##1 !strb) else $error("strobe");
	AST_STROBE_LOW: assert property (strb && init |-> !SERIAL_SHIFT_CLOCK) else $error("strobe clk");
	AST_DATA_HOLD: assert property (SERIAL_SHIFT_CLOCK && init |-> $stable(SERIAL_DATA_LINE)) else $error("data");
	AST_HALF_BIT: assert property ($rose(sck) && init |-> sck [*4] ##1 !sck) else $error("half bit");
	AST_CHAIN_BITS: assert property ($rose(DELAY_CHAIN_LATCH_STROBE) && init |-> rise_ff == 7'h50) else $error("chain");
	AST_CONV_BITS: assert property ($rose(conv) && init |-> rise_ff == 7'h0F && chain_ff) else $error("conv");
	AST_INT_OFF: assert property (!INT_MODE [*6] |-> !INTEGRATING) else $error("integrating");
	// Main scenarios reached
	cover property ($rose(DELAY_CHAIN_LATCH_STROBE) && init);
	cover property ($rose(CONVERTER2_LATCH_STROBE) && DEFAULTS_DONE);
	cover property ($fell(INTEGRATING));
endmodule // dccl_monitor

// ---- dccl_targets.sv ----
// Behavioural delay chain and two converters.
// Assumes the loader's serial outputs.
`timescale 1ns/100ps
module dccl_targets (
	input wire sclk,     // Shift clock
	input wire serial_data_line,    // Data line
	input wire ld_chain, // Chain strobe
	input wire ld_conv1, // Strobe 1
	input wire ld_conv2  // Strobe 2
);
	reg [79:0] shift_ff = 80'h0; // Cascade path
	reg [79:0] chain_ff = 80'h0; // Latched codes
	reg [14:0] c1_ff [0:3];      // Converter 1
	reg [14:0] c2_ff [0:3];      // Converter 2
	integer    c1_cnt = 0;       // Loads 1
	integer    c2_cnt = 0;       // Loads 2
	// Rising edge takes data; first bit ends furthest down
	always @(posedge sclk) shift_ff <= {shift_ff[78:0], serial_data_line};
	// Whole chain at once, a partial shift never lands
	always @(posedge ld_chain) chain_ff <= shift_ff;
	// Own strobe per converter
	always @(posedge ld_conv1) begin
		c1_ff[c1_cnt % 4] <= shift_ff[14:0];
		c1_cnt = c1_cnt + 1;
	end
	always @(posedge ld_conv2) begin
		c2_ff[c2_cnt % 4] <= shift_ff[14:0];
		c2_cnt = c2_cnt + 1;
	end
endmodule // dccl_targets

// ---- dccl_loader_tb.sv ----
// Self-checking bench for the loader.
// Assumes dccl_targets on the serial outputs.
`timescale 1ns/100ps
`include "dccl_defs.vh"
module dccl_loader_tb;
	localparam [79:0] CHN = {`DCCL_DLY_OUTCLK, `DCCL_DLY_REF2, `DCCL_DLY_REF1, `DCCL_DLY_DAT2, `DCCL_DLY_DAT1,
		`DCCL_DLY_HP1A, `DCCL_DLY_HP1B, `DCCL_DLY_HP2A, `DCCL_DLY_HP2B, `DCCL_DLY_RST};
	localparam [59:0] CNV = {`DCCL_CONV_W0, `DCCL_CONV_W1, `DCCL_CONV_W2, `DCCL_CONV_W3};
	reg        CLOCK = 1'b0, RST = 1'b1, EXT_SCLK = 1'b0, EXT_DATA = 1'b0, UNIT_TICK = 1'b0, INT_MODE = 1'b0;
	reg        EXT_CHAIN_LD = 1'b0, EXT_CONV1_LD = 1'b0, EXT_CONV2_LD = 1'b0;
	reg  [7:0] INT_UNITS = 8'h03;
	wire       SCK, SDA, LDC, LD1, LD2, PIX, INTG, DONE;
	integer    num_errors = 0;
	integer    comparisons = 0;
	always #2 CLOCK = ~CLOCK;
	dccl_loader i_dccl_loader (.CLOCK(CLOCK), .RST(RST), .EXT_SCLK(EXT_SCLK), .EXT_DATA(EXT_DATA),
		.EXT_CHAIN_LD(EXT_CHAIN_LD), .EXT_CONV1_LD(EXT_CONV1_LD), .EXT_CONV2_LD(EXT_CONV2_LD),
		.UNIT_TICK(UNIT_TICK), .INT_MODE(INT_MODE), .INT_UNITS(INT_UNITS), .SERIAL_SHIFT_CLOCK(SCK),
		.SERIAL_DATA_LINE(SDA), .DELAY_CHAIN_LATCH_STROBE(LDC), .CONVERTER1_LATCH_STROBE(LD1),
		.CONVERTER2_LATCH_STROBE(LD2), .PIXEL_ENABLE(PIX), .INTEGRATING(INTG), .DEFAULTS_DONE(DONE));
	dccl_targets i_dccl_targets (.sclk(SCK), .serial_data_line(SDA), .ld_chain(LDC), .ld_conv1(LD1), .ld_conv2(LD2));
	// ************************************************************
	// Shared tasks and scenarios
	// ************************************************************
	task conclude;
		begin
			if (num_errors == 0 && comparisons > 0) $display("Result: passed");
			else $display("Result: failed");
			$finish;
		end
	endtask
	task chk(input string nm, input logic [79:0] e, input logic [79:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("BAD %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge CLOCK);
			#1;
		end
	endtask
	task ext_send(input logic [79:0] v, input integer nb, input integer sel);
		integer i;
		begin
			for (i = nb - 1; i >= 0; i = i - 1) begin
				EXT_DATA = v[i];
				#32 EXT_SCLK = 1'b1;
				#32 EXT_SCLK = 1'b0;
			end
			EXT_DATA = ~EXT_DATA;
			#32 {EXT_CONV2_LD, EXT_CONV1_LD, EXT_CHAIN_LD} = 3'h1 << sel;
			#64 {EXT_CONV2_LD, EXT_CONV1_LD, EXT_CHAIN_LD} = 3'h0;
			cyc(20);
		end
	endtask
	// Reset cut short mid-chain; pins ignored while loading
	task t_restart;
		begin
			cyc(20);
			RST = 1'b0;
			cyc(100);
			EXT_CHAIN_LD = 1'b1;
			cyc(200);
			EXT_CHAIN_LD = 1'b0;
			chk("early done", 0, DONE);
			chk("early chain", 0, i_dccl_targets.chain_ff);
			RST = 1'b1;
			cyc(20);
			RST = 1'b0;
		end
	endtask
	task t_defaults;
		integer i;
		begin
			for (i = 0; i < 4000 && DONE !== 1'b1; i = i + 1) cyc(1);
			chk("done", 1, DONE);
			if (DONE !== 1'b1) conclude;
			chk("chain", CHN, i_dccl_targets.chain_ff);
			for (i = 0; i < 4; i = i + 1) begin
				chk("conv1", CNV[59 - 15 * i -: 15], i_dccl_targets.c1_ff[i]);
				chk("conv2", CNV[59 - 15 * i -: 15], i_dccl_targets.c2_ff[i]);
			end
			chk("loads1", 4, i_dccl_targets.c1_cnt);
			chk("loads2", 4, i_dccl_targets.c2_cnt);
		end
	endtask
	task t_pixel;
		integer k, n;
		begin
			n = 0;
			for (k = 0; k < 40; k = k + 1) begin
				cyc(1);
				n = n + PIX;
			end
			chk("pixel", 40 / `DCCL_PIX_DIV, n);
		end
	endtask
	// Ticks every 40 cycles; three ticks long
	task t_integ;
		integer k, len, got;
		begin
			len = 0;
			got = 0;
			INT_MODE = 1'b1;
			for (k = 0; k < 400; k = k + 1) begin
				cyc(1);
				UNIT_TICK = (k % 40) < 8;
				if (INTG === 1'b1) len = len + 1;
				else if (len > 0 && got == 0) got = len;
			end
			chk("integ", 120, got);
			INT_MODE = 1'b0;
			cyc(10);
			chk("integ off", 0, INTG);
		end
	endtask
	task t_external;
		begin
			ext_send(80'h5A3, 15, 2);
			chk("ext conv2", 15'h5A3, i_dccl_targets.c2_ff[0]);
			chk("conv1 kept", 4, i_dccl_targets.c1_cnt);
			chk("chain kept", CHN, i_dccl_targets.chain_ff);
			ext_send(~CHN, 80, 0);
			chk("ext chain", ~CHN, i_dccl_targets.chain_ff);
		end
	endtask
	initial begin
		t_restart;
		t_defaults;
		t_pixel;
		t_integ;
		t_external;
		conclude;
	end
endmodule // dccl_loader_tb
bind dccl_loader dccl_monitor i_dccl_monitor (.CLOCK(CLOCK), .RST(RST), .INT_MODE(INT_MODE),
	.SERIAL_SHIFT_CLOCK(SERIAL_SHIFT_CLOCK), .SERIAL_DATA_LINE(SERIAL_DATA_LINE),
	.DELAY_CHAIN_LATCH_STROBE(DELAY_CHAIN_LATCH_STROBE), .CONVERTER1_LATCH_STROBE(CONVERTER1_LATCH_STROBE),
	.CONVERTER2_LATCH_STROBE(CONVERTER2_LATCH_STROBE), .PIXEL_ENABLE(PIXEL_ENABLE),
	.INTEGRATING(INTEGRATING), .DEFAULTS_DONE(DEFAULTS_DONE));
